// [hw/pug_gpio_port.sv]
`timescale 1ns/10ps
module pug_gpio_port
   import pug_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // AXI4-Lite write address and data
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // On-chip timer: enable, per-channel output compare select and level
   input wire logic timer_enable,
   input wire logic [3:0] timer_oc_enable,
   input wire logic [3:0] timer_oc_level,
   // On-chip PWM: per-channel enable and waveform
   input wire logic [7:0] pwm_enable,
   input wire logic [7:0] pwm_wave,
   // Pads
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_b,
   output logic [7:0] pin_reduced_drive,
   output logic [7:0] pin_pull_on,
   output logic [7:0] pin_pull_down,
   // Synchronised levels toward timer input capture
   output logic [7:0] pin_level_sync
);
   typedef enum logic [1:0] {PUG_W_IDLE, PUG_W_RESP} pug_wstate_type;

   logic [7:0] port_output_data;
   logic [7:0] port_direction;
   logic [7:0] port_drive_strength;
   logic [7:0] port_pull_enable;
   logic [7:0] port_pull_polarity;
   logic [7:0] port_function_routing;
   logic [7:0] pin_sync;
   pug_wstate_type wstate;
   logic aw_held;
   logic w_held;
   logic [4:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   pug_sync u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pin_async(pin_in),
      .pin_sync(pin_sync)
   );

   // Per-pin ownership: which function drives the pin and its direction
   logic [7:0] timer_owns;
   logic [7:0] pwm_owns;
   logic [7:0] next_pin_out;
   logic [7:0] next_oe_b;
   logic [7:0] next_pull_on;
   logic [7:0] next_pull_down;
   logic [7:0] next_reduced;

   genvar gi;
   generate
      for (gi = 0; gi < PUG_PINS; gi++) begin : g_pin
         wire logic timer_req;
         wire logic is_output;
         if (gi < PUG_TIMER_PINS) begin : g_tim
            // Only the lower pins carry timer compare outputs
            assign timer_req = timer_enable & timer_oc_enable[gi];
         end else begin : g_notim
            assign timer_req = 1'b0;
         end
         // Routing bit resolves a clash; otherwise whoever is enabled wins
         assign timer_owns[gi] = timer_req & ~(pwm_enable[gi] & port_function_routing[gi]);
         assign pwm_owns[gi] = pwm_enable[gi] & ~(timer_req & ~port_function_routing[gi]);
         // Peripheral outranks the direction bit; capture pins fall through to it
         assign is_output = timer_owns[gi] | pwm_owns[gi] | port_direction[gi];
         assign next_oe_b[gi] = ~is_output;
         assign next_pin_out[gi] = timer_owns[gi] ? (gi < PUG_TIMER_PINS ?
            timer_oc_level[gi % PUG_TIMER_PINS] : 1'b0) :
            pwm_owns[gi] ? pwm_wave[gi] : port_output_data[gi];
         assign next_reduced[gi] = is_output & port_drive_strength[gi];
         // Polarity only counts for a true input with pull enabled
         assign next_pull_on[gi] = ~is_output & port_pull_enable[gi];
         assign next_pull_down[gi] = ~is_output & port_pull_enable[gi] &
            port_pull_polarity[gi];
      end
   endgenerate

   // Pad controls registered so every output comes from a flop
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= PUG_RESET_BYTE;
         pin_oe_b <= 8'hff;
         pin_reduced_drive <= PUG_RESET_BYTE;
         pin_pull_on <= PUG_RESET_BYTE;
         pin_pull_down <= PUG_RESET_BYTE;
         pin_level_sync <= PUG_RESET_BYTE;
      end else begin
         pin_out <= next_pin_out;
         pin_oe_b <= next_oe_b;
         pin_reduced_drive <= next_reduced;
         pin_pull_on <= next_pull_on;
         pin_pull_down <= next_pull_down;
         pin_level_sync <= pin_sync;
      end
   end

   // Write channel decode: address and data may arrive in either order
   wire logic w_fire = aw_held & w_held & (wstate == PUG_W_IDLE);
   wire logic sel_out = aw_addr == PUG_OFF_OUTPUT_DATA;
   wire logic sel_lvl = aw_addr == PUG_OFF_PIN_LEVELS;
   wire logic sel_dir = aw_addr == PUG_OFF_DIRECTION;
   wire logic sel_drv = aw_addr == PUG_OFF_DRIVE_STRENGTH;
   wire logic sel_pen = aw_addr == PUG_OFF_PULL_ENABLE;
   wire logic sel_pol = aw_addr == PUG_OFF_PULL_POLARITY;
   wire logic sel_rte = aw_addr == PUG_OFF_FUNCTION_ROUTING;
   wire logic w_mapped = sel_out | sel_lvl | sel_dir | sel_drv | sel_pen | sel_pol | sel_rte;
   wire logic w_lane0 = w_fire & w_strb[0];
   wire logic [7:0] wbyte = w_data[7:0];

   // Address and data capture, one write in flight
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 5'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (w_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (w_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Ready only while the holding slot is empty and no response is pending
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & (wstate == PUG_W_IDLE);
         s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & (wstate == PUG_W_IDLE);
      end
   end

   // Response state machine
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wstate <= PUG_W_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PUG_RESP_OKAY;
      end else begin
         case (wstate)
            PUG_W_IDLE: begin
               if (w_fire) begin
                  wstate <= PUG_W_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= w_mapped ? PUG_RESP_OKAY : PUG_RESP_SLVERR;
               end
            end
            PUG_W_RESP: begin
               if (s_axi_bready) begin
                  wstate <= PUG_W_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wstate <= PUG_W_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // Configuration registers accept writes at any time; pin levels ignore them
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port_output_data <= PUG_RESET_BYTE;
         port_direction <= PUG_RESET_BYTE;
         port_drive_strength <= PUG_RESET_BYTE;
         port_pull_enable <= PUG_RESET_BYTE;
         port_pull_polarity <= PUG_RESET_BYTE;
         port_function_routing <= PUG_RESET_BYTE;
      end else begin
         if (w_lane0 & sel_out) port_output_data <= wbyte;
         if (w_lane0 & sel_dir) port_direction <= wbyte;
         if (w_lane0 & sel_drv) port_drive_strength <= wbyte;
         if (w_lane0 & sel_pen) port_pull_enable <= wbyte;
         if (w_lane0 & sel_pol) port_pull_polarity <= wbyte;
         if (w_lane0 & sel_rte) port_function_routing <= wbyte;
      end
   end

   // Read path; pin values lag the pads by the synchroniser depth
   wire logic [7:0] out_read = (port_direction & port_output_data) |
      (~port_direction & pin_sync);
   logic [7:0] rd_byte;
   logic rd_ok;
   always_comb begin
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         PUG_OFF_OUTPUT_DATA: rd_byte = out_read;
         PUG_OFF_PIN_LEVELS: rd_byte = pin_sync;
         PUG_OFF_DIRECTION: rd_byte = port_direction;
         PUG_OFF_DRIVE_STRENGTH: rd_byte = port_drive_strength;
         PUG_OFF_PULL_ENABLE: rd_byte = port_pull_enable;
         PUG_OFF_PULL_POLARITY: rd_byte = port_pull_polarity;
         PUG_OFF_FUNCTION_ROUTING: rd_byte = port_function_routing;
         default: rd_ok = 1'b0;
      endcase
   end

   // Read handshake: arready high while idle, data one cycle later
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= PUG_RESP_OKAY;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? PUG_RESP_OKAY : PUG_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (~s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Reset leaves every pin an undriven input
   AST_RESET_INPUTS: assert property (@(posedge core_clk)
      $rose(rst_b) |-> pin_oe_b == 8'hff) else $error("pins driven after reset");
   // Output data and pad levels come out of reset cleared
   AST_RESET_DATA: assert property (@(posedge core_clk)
      $rose(rst_b) |-> port_output_data == PUG_RESET_BYTE && pin_out == PUG_RESET_BYTE)
      else $error("output data not cleared by reset");
   // A PWM channel that owns a pin drives it one cycle later
   AST_PWM_FORCES_OUT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pwm_enable[5] & ~timer_enable) |=> ~pin_oe_b[5] && pin_out[5] == $past(pwm_wave[5]))
      else $error("pwm did not take pin");
   // Upper pins never follow the timer
   AST_TIMER_LOWER_ONLY: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pwm_enable[4] == 1'b0 && port_direction[4] == 1'b0) |=> pin_oe_b[4])
      else $error("upper pin driven");
   // Compare owner forces the lower pin out
   AST_TIMER_FORCES_OUT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (timer_enable & timer_oc_enable[0] & ~pwm_enable[0]) |=>
      ~pin_oe_b[0] && pin_out[0] == $past(timer_oc_level[0])) else $error("timer lost pin");
   // Routing bit set on a clash hands the pin to PWM
   AST_ROUTING_PWM: assert property (@(posedge core_clk) disable iff (!rst_b)
      (timer_enable & timer_oc_enable[1] & pwm_enable[1] & port_function_routing[1]) |=>
      pin_out[1] == $past(pwm_wave[1])) else $error("routing ignored");
   // Capture pin with direction zero stays an input
   AST_CAPTURE_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
      (timer_enable & ~timer_oc_enable[2] & ~pwm_enable[2] & ~port_direction[2]) |=>
      pin_oe_b[2]) else $error("capture pin driven");
   // Pull only on inputs, polarity gated by pull enable
   AST_PULL_GATED: assert property (@(posedge core_clk) disable iff (!rst_b)
      ~pin_oe_b[3] |-> ~pin_pull_on[3] && ~pin_pull_down[3]) else $error("pull on output");
   AST_DRIVE_INPUT: assert property (@(posedge core_clk) disable iff (!rst_b)
      pin_oe_b[6] |-> ~pin_reduced_drive[6]) else $error("drive on input");
   // A plain GPIO output carries its drive setting to the pad
   AST_DRIVE_OUTPUT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (port_direction[6] & ~pwm_enable[6]) |=>
      pin_reduced_drive[6] == $past(port_drive_strength[6])) else $error("drive lost");
   // An unowned input with pull enabled takes the polarity bit
   AST_PULL_POLARITY: assert property (@(posedge core_clk) disable iff (!rst_b)
      (~port_direction[2] & ~pwm_enable[2] & ~(timer_enable & timer_oc_enable[2]) &
      port_pull_enable[2]) |=> pin_pull_on[2] && pin_pull_down[2] == $past(port_pull_polarity[2]))
      else $error("pull polarity ignored");
   // A GPIO output with no peripheral owner shows the stored data bit
   AST_GPIO_OUT: assert property (@(posedge core_clk) disable iff (!rst_b)
      (port_direction[7] & ~pwm_enable[7]) |=>
      ~pin_oe_b[7] && pin_out[7] == $past(port_output_data[7])) else $error("gpio not driven");

   // A read request is taken at this edge; its answer stands from the next one
   sequence pug_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // Pins with the direction bit set read back the stored bit, the others the synchronised level
   AST_OUT_READ_REG: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pug_rd_taken ##0 (s_axi_araddr == PUG_OFF_OUTPUT_DATA && port_direction[0])) |=>
      s_axi_rdata[0] == $past(port_output_data[0])) else $error("stored bit not read");
   AST_OUT_READ_PIN: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pug_rd_taken ##0 (s_axi_araddr == PUG_OFF_OUTPUT_DATA && !port_direction[4])) |=>
      s_axi_rdata[4] == $past(pin_sync[4])) else $error("pin level not read");
   // Pin levels always read the synchroniser, whatever the configuration
   AST_LEVELS_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pug_rd_taken ##0 (s_axi_araddr == PUG_OFF_PIN_LEVELS)) |=>
      s_axi_rdata[7:0] == $past(pin_sync)) else $error("pin levels wrong");
   // Pin level reaches the read path after two synchroniser edges; the first
   // edges after reset are left out, the stages still hold their reset zeros
   AST_SYNC_LAG: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($past(rst_b) && $past(rst_b, 2)) |-> pin_sync == $past(pin_in, 2))
      else $error("sync depth wrong");
endmodule

// [hw/pug_pkg.sv]
package pug_pkg;
   // Register byte addresses on the AXI4-Lite slave
   localparam logic [4:0] PUG_OFF_OUTPUT_DATA = 5'h00;
   localparam logic [4:0] PUG_OFF_PIN_LEVELS = 5'h04;
   localparam logic [4:0] PUG_OFF_DIRECTION = 5'h08;
   localparam logic [4:0] PUG_OFF_DRIVE_STRENGTH = 5'h0c;
   localparam logic [4:0] PUG_OFF_PULL_ENABLE = 5'h10;
   localparam logic [4:0] PUG_OFF_PULL_POLARITY = 5'h14;
   localparam logic [4:0] PUG_OFF_FUNCTION_ROUTING = 5'h18;
   // Widths and reset values
   localparam int PUG_PINS = 8;
   localparam int PUG_TIMER_PINS = 4;
   localparam logic [7:0] PUG_RESET_BYTE = 8'h00;
   localparam logic [1:0] PUG_RESP_OKAY = 2'h0;
   localparam logic [1:0] PUG_RESP_SLVERR = 2'h2;
   // Synchroniser depth on the pin input path
   localparam int PUG_SYNC_STAGES = 2;
endpackage

// [hw/pug_sync.sv]
`timescale 1ns/10ps
module pug_sync
   import pug_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Asynchronous pin levels in, synchronised levels out
   input wire logic [7:0] pin_async,
   output logic [7:0] pin_sync
);
   logic [7:0] stage_one;

   // Two flops per pin; the first stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_one <= PUG_RESET_BYTE;
         pin_sync <= PUG_RESET_BYTE;
      end else begin
         stage_one <= pin_async;
         pin_sync <= stage_one;
      end
   end
endmodule

// [verif/pug_pad_model.sv]
`timescale 1ns/10ps
module pug_pad_model
   import pug_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Pad controls from the port
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_b,
   input wire logic [7:0] pin_pull_on,
   input wire logic [7:0] pin_pull_down,
   // Outside driver on pads the port leaves alone
   input wire logic ext_en,
   input wire logic [7:0] ext_val,
   // Resolved pad level
   output logic [7:0] pad
);
   logic [7:0] last;
   // Last level kept, so a floating pad shows its inverse and never a stale value
   always_ff @(posedge core_clk) begin
      last <= pad;
   end
   // Port drive wins, then the outside driver, then the pull device, else float
   always_comb begin
      for (int i = 0; i < PUG_PINS; i++) begin
         if (!pin_oe_b[i]) begin
            pad[i] = pin_out[i];
         end else if (ext_en) begin
            pad[i] = ext_val[i];
         end else if (pin_pull_on[i]) begin
            pad[i] = ~pin_pull_down[i];
         end else begin
            pad[i] = ~last[i];
         end
      end
   end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/10ps
module tb_top
   import pug_pkg::*;
;
   logic core_clk = 0, rst_b = 0;
   logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, timer_enable = 0, ext_en = 1;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rng = 32'h87ec6fca;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] timer_oc_enable = 0, timer_oc_level = 0;
   logic [7:0] pwm_enable = 0, pwm_wave = 0, ext_val = 8'h5a, pin_in, pin_out, pin_oe_b;
   logic [7:0] pin_reduced_drive, pin_pull_on, pin_pull_down, pin_level_sync;
   logic [7:0] dir = 0, od = 0, rt = 0, rd = 0, pe = 0, pps = 0, e_drv, e_out, e_pad;
   logic [33:0] exp_q[$];
   int error_cnt = 0, num_checks = 0, cyc = 0;
   pug_gpio_port dut (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_enable,
      .timer_oc_enable, .timer_oc_level, .pwm_enable, .pwm_wave, .pin_in, .pin_out,
      .pin_oe_b, .pin_reduced_drive, .pin_pull_on, .pin_pull_down, .pin_level_sync);
   pug_pad_model far (.core_clk, .pin_out, .pin_oe_b, .pin_pull_on, .pin_pull_down,
      .ext_en, .ext_val, .pad(pin_in));
   // Clock, 10 ns period
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic complete_run();
      $display("Errors %0d, checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t pin got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each released once taken
   task automatic axi_wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, tw, b;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready === 1;
         tw = s_axi_wvalid && s_axi_wready === 1;
         b = s_axi_bvalid === 1;
         if (b) chk_v({6'h0, s_axi_bresp}, {6'h0, er});
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (b) s_axi_bready <= 0;
      end while (!b);
   endtask
   // Read: expectation noted in the queue, compared by the monitor below
   task automatic axi_rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ta, r;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      exp_q.push_back({er, 24'h0, d});
      do begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready === 1;
         r = s_axi_rvalid === 1;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 0;
         if (r) s_axi_rready <= 0;
      end while (!r);
   endtask
   // Read monitor: sampled between edges, where the answer is settled
   always @(negedge core_clk) begin
      if (s_axi_rvalid === 1 && s_axi_rready === 1) begin
         if (exp_q.size() == 0) chk_rd(34'h0, 34'h1);
         else chk_rd({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   // Expected pad state: function beats GPIO, routing decides a tie
   task automatic calc();
      logic [7:0] st, own_p, own_t;
      st = {4'h0, timer_oc_enable & {4{timer_enable}}};
      own_p = pwm_enable & (~st | rt);
      own_t = st & ~own_p;
      e_drv = own_p | own_t | dir;
      e_out = (own_p & pwm_wave) | (own_t & {4'h0, timer_oc_level}) | (~own_p & ~own_t & od);
      e_pad = (e_out & e_drv) | (~e_drv & (ext_en ? ext_val : ~pps));
   endtask
   task automatic pin_check();
      @(negedge core_clk);
      chk_v(~pin_oe_b, e_drv);
      chk_v(pin_out, e_out);
      chk_v(pin_reduced_drive, rd & e_drv);
      chk_v(pin_pull_on, pe & ~e_drv);
      chk_v(pin_pull_down, pps & pe & ~e_drv);
      chk_v(pin_level_sync, e_pad);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1;
      // Level output trails the pads by two synchroniser stages and its own flop
      repeat (3) @(posedge core_clk);
      calc();
      pin_check();
      for (int a = 8; a <= 24; a += 4) axi_rd(a[4:0], 8'h00, PUG_RESP_OKAY);
      axi_rd(5'h1c, 8'h00, PUG_RESP_SLVERR);
      axi_wr(5'h1c, 8'hff, PUG_RESP_SLVERR);
      axi_wr(PUG_OFF_PIN_LEVELS, 8'ha5, PUG_RESP_OKAY);
      axi_rd(PUG_OFF_PIN_LEVELS, ext_val, PUG_RESP_OKAY);
      dir = 8'hff;
      axi_wr(PUG_OFF_DIRECTION, dir, PUG_RESP_OKAY);
      axi_rd(PUG_OFF_OUTPUT_DATA, 8'h00, PUG_RESP_OKAY);
      // Random mixes of timer, PWM, routing and GPIO settings
      repeat (40) begin
         rng = xs(rng);
         timer_enable <= rng[0];
         ext_en <= rng[1];
         timer_oc_enable <= rng[7:4];
         timer_oc_level <= rng[11:8];
         pwm_enable <= rng[23:16];
         pwm_wave <= rng[31:24];
         pe = rng[1] ? rng[19:12] : 8'hff;
         rng = xs(rng);
         ext_val <= rng[7:0];
         {dir, od, rt} = rng[31:8];
         rng = xs(rng);
         {rd, pps} = rng[15:0];
         axi_wr(PUG_OFF_DIRECTION, dir, PUG_RESP_OKAY);
         axi_wr(PUG_OFF_OUTPUT_DATA, od, PUG_RESP_OKAY);
         axi_wr(PUG_OFF_FUNCTION_ROUTING, rt, PUG_RESP_OKAY);
         axi_wr(PUG_OFF_DRIVE_STRENGTH, rd, PUG_RESP_OKAY);
         axi_wr(PUG_OFF_PULL_ENABLE, pe, PUG_RESP_OKAY);
         axi_wr(PUG_OFF_PULL_POLARITY, pps, PUG_RESP_OKAY);
         calc();
         repeat (5) @(posedge core_clk);
         pin_check();
         axi_rd(PUG_OFF_OUTPUT_DATA, (od & dir) | (e_pad & ~dir), PUG_RESP_OKAY);
         axi_rd(PUG_OFF_PIN_LEVELS, e_pad, PUG_RESP_OKAY);
         axi_rd(PUG_OFF_FUNCTION_ROUTING, rt, PUG_RESP_OKAY);
      end
      repeat (4) @(posedge core_clk);
      complete_run();
   end
endmodule
